// ===== pkg/tcr_pkg.sv
// Purpose: Constants and types for the sixteen-bit timer/counter
// Assumes: AHB-Lite register access, one core clock
// Notes: Count bytes hold their value through reset

package tcr_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TCR_OFS_CTRL = 8'h00;
  localparam logic [7:0] TCR_OFS_COUNT_LO = 8'h04;
  localparam logic [7:0] TCR_OFS_COUNT_HI = 8'h08;
  localparam logic [7:0] TCR_OFS_STATUS = 8'h0C;
  localparam logic [7:0] TCR_OFS_IRQ_EN = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int TCR_CTRL_WIDTH = 6;
  localparam logic [5:0] TCR_CTRL_RESET = 6'h00;
  localparam int TCR_FLAG_BIT = 0;
  localparam logic [3:0] TCR_MODE_SPECIAL_TRIG = 4'hB;
  localparam logic [15:0] TCR_COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] TCR_COUNT_ZERO = 16'h0000;
  localparam int TCR_SYNC_STAGES = 2;

  // Prescale field encodings
  localparam logic [1:0] TCR_PRE_1 = 2'h0;
  localparam logic [1:0] TCR_PRE_2 = 2'h1;
  localparam logic [1:0] TCR_PRE_4 = 2'h2;
  localparam logic [1:0] TCR_PRE_8 = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] input_prescale_field;
    logic osc_enable_bit;
    logic sync_bypass_bit;
    logic clock_source_select;
    logic timer_run_bit;
  } tcr_ctrl_type;

  typedef struct packed {
    logic [3:0] compare_mode_field;
    logic [15:0] compare_value_pair;
    logic adc_enable;
  } tcr_cmp_type;
endpackage

// ===== verilog/tcr_edge_detect.sv
// Purpose: Rising edge pulse from the external count input
// Assumes: Pin input sampled on core_clk
// Notes: Arms only after a falling edge seen while enabled
`timescale 1ns/1ps
`default_nettype none
module tcr_edge_detect
  import tcr_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic pin_in,
  input wire logic bypass,
  input wire logic arm_clr,
  output logic rise
);
  logic [TCR_SYNC_STAGES-1:0] sync_q;
  logic sel;
  logic prev;
  logic armed;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[TCR_SYNC_STAGES-2:0], pin_in};
    end
  end

  assign sel = bypass ? pin_in : sync_q[TCR_SYNC_STAGES-1];

  // ----------------------------------------------------------------
  // Edge and arming
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prev <= 1'b0;
    end else begin
      prev <= sel;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      armed <= 1'b0;
    end else if (arm_clr) begin
      armed <= 1'b0;
    end else if (prev && !sel) begin
      armed <= 1'b1;
    end
  end

  assign rise = armed && !prev && sel;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_no_rise_unarmed: assert property (@(posedge core_clk) disable iff (!nrst)
    !armed |-> !rise) else $error("rise before falling edge");
  a_arm_after_fall: assert property (@(posedge core_clk) disable iff (!nrst)
    (prev && !sel && !arm_clr) |=> armed) else $error("not armed");
endmodule // tcr_edge_detect
`default_nettype wire

// ===== verilog/tcr_timer.sv
// Purpose: Sixteen-bit timer/counter with prescaler and compare reset
// Assumes: AHB-Lite slave, zero wait states, word accesses
// Notes: Count bytes carry no reset; control clears on nrst
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tcr_timer
  import tcr_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ext_clk_pin,
  input wire logic osc_in_pin,
  output logic osc_out_en,
  input wire logic sleep,
  input wire tcr_cmp_type cmp,
  output logic adc_start,
  output logic irq
);
  tcr_ctrl_type ctrl;
  logic [15:0] count;
  logic [15:0] next_count;
  logic [2:0] pre;
  logic [2:0] pre_mask;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic wr_ctrl, wr_lo, wr_hi, wr_stat, wr_ien;
  logic ext_rise, pulse_in, tick, count_ok, inc, trig, wrap;
  logic async_mode;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic acc;
  assign acc = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= acc && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  assign wr_ctrl = wr_pend && (wr_addr == TCR_OFS_CTRL);
  assign wr_lo = wr_pend && (wr_addr == TCR_OFS_COUNT_LO);
  assign wr_hi = wr_pend && (wr_addr == TCR_OFS_COUNT_HI);
  assign wr_stat = wr_pend && (wr_addr == TCR_OFS_STATUS);
  assign wr_ien = wr_pend && (wr_addr == TCR_OFS_IRQ_EN);

  // Registered read data taken from the settled count
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      if (haddr[7:0] == TCR_OFS_CTRL) begin
        hrdata <= {26'h0, ctrl};
      end else if (haddr[7:0] == TCR_OFS_COUNT_LO) begin
        hrdata <= {24'h0, count[7:0]};
      end else if (haddr[7:0] == TCR_OFS_COUNT_HI) begin
        hrdata <= {24'h0, count[15:8]};
      end else if (haddr[7:0] == TCR_OFS_STATUS) begin
        hrdata <= {31'h0, overflow_flag};
      end else if (haddr[7:0] == TCR_OFS_IRQ_EN) begin
        hrdata <= {31'h0, overflow_irq_enable};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and enables
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= TCR_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= hwdata[TCR_CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      overflow_irq_enable <= 1'b0;
    end else if (wr_ien) begin
      overflow_irq_enable <= hwdata[TCR_FLAG_BIT];
    end
  end

  assign osc_out_en = ctrl.osc_enable_bit;
  assign async_mode = ctrl.clock_source_select && ctrl.sync_bypass_bit;

  // ----------------------------------------------------------------
  // Input edge and prescaler
  // ----------------------------------------------------------------
  tcr_edge_detect u_edge (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_in(ctrl.osc_enable_bit ? osc_in_pin : ext_clk_pin),
    .bypass(ctrl.sync_bypass_bit),
    .arm_clr(!(ctrl.timer_run_bit && ctrl.clock_source_select)),
    .rise(ext_rise)
  );

  assign pulse_in = ctrl.timer_run_bit &&
    (ctrl.clock_source_select ? ext_rise : 1'b1);

  always_comb begin
    case (ctrl.input_prescale_field)
      TCR_PRE_1: pre_mask = 3'h0;
      TCR_PRE_2: pre_mask = 3'h1;
      TCR_PRE_4: pre_mask = 3'h3;
      default: pre_mask = 3'h7;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pre <= 3'h0;
    end else if (wr_lo || wr_hi) begin
      pre <= 3'h0;
    end else if (pulse_in) begin
      pre <= (pre & pre_mask) == pre_mask ? 3'h0 : pre + 3'h1;
    end
  end

  assign tick = pulse_in && ((pre & pre_mask) == pre_mask);
  // Synced counter and timer halt in sleep; prescaler keeps going
  assign count_ok = !sleep || async_mode;
  assign inc = tick && count_ok;

  // ----------------------------------------------------------------
  // Count, trigger and overflow
  // ----------------------------------------------------------------
  assign trig = (cmp.compare_mode_field == TCR_MODE_SPECIAL_TRIG) &&
    (count == cmp.compare_value_pair) && !async_mode;
  assign wrap = inc && (count == TCR_COUNT_MAX) && !trig &&
    !wr_lo && !wr_hi;

  always_comb begin
    next_count = count;
    if (inc) begin
      next_count = count + 16'h0001;
    end
    if (trig) begin
      next_count = TCR_COUNT_ZERO;
    end
    if (wr_lo) begin
      next_count = {count[15:8], hwdata[7:0]};
    end
    if (wr_hi) begin
      next_count = {hwdata[7:0], count[7:0]};
    end
  end

  // No reset: contents survive every reset
  always_ff @(posedge core_clk) begin
    count <= next_count;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= trig && cmp.adc_enable && !wr_lo && !wr_hi;
    end
  end

  // Set wins over the write-one clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      overflow_flag <= 1'b0;
    end else if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (wr_stat && hwdata[TCR_FLAG_BIT]) begin
      overflow_flag <= 1'b0;
    end
  end

  assign irq = overflow_flag && overflow_irq_enable;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_trig_clears_count: assert property (@(posedge core_clk) disable iff (!nrst)
    (trig && !wr_lo && !wr_hi) |=> count == 16'h0000)
    else $error("trigger did not clear count");
  a_write_beats_trig: assert property (@(posedge core_clk) disable iff (!nrst)
    (trig && wr_lo) |=> count[7:0] == $past(hwdata[7:0]))
    else $error("write lost to trigger");
  a_async_no_trig: assert property (@(posedge core_clk) disable iff (!nrst)
    async_mode |-> !trig) else $error("trigger in async mode");
  a_wrap_sets_flag: assert property (@(posedge core_clk) disable iff (!nrst)
    wrap |=> overflow_flag && count == 16'h0000)
    else $error("wrap missed flag");
  a_irq_gated: assert property (@(posedge core_clk) disable iff (!nrst)
    irq == (overflow_flag && overflow_irq_enable))
    else $error("interrupt gating wrong");
  a_write_clears_pre: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_lo || wr_hi) |=> pre == 3'h0)
    else $error("prescaler not cleared");
  a_sleep_sync_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    (sleep && !async_mode && !trig && !wr_lo && !wr_hi) |=>
    count == $past(count)) else $error("counted in sleep");
  a_osc_follows_bit: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_ctrl |=> osc_out_en == $past(hwdata[3]))
    else $error("oscillator enable wrong");
  // Count has no reset, so the hold is judged by stability
  a_stop_holds: assert property (@(posedge core_clk) disable iff (!nrst)
    (!ctrl.timer_run_bit && !trig && !wr_lo && !wr_hi) |=>
    $stable(count)) else $error("stopped counter moved");
  a_adc_pulse: assert property (@(posedge core_clk) disable iff (!nrst)
    adc_start |-> $past(trig) && $past(cmp.adc_enable))
    else $error("conversion start without trigger");

  c_wrap: cover property (@(posedge core_clk) disable iff (!nrst) wrap);
  c_trig: cover property (@(posedge core_clk) disable iff (!nrst)
    trig && cmp.adc_enable);
  c_async_sleep: cover property (@(posedge core_clk) disable iff (!nrst)
    inc && sleep && async_mode);
  c_flag_clear: cover property (@(posedge core_clk) disable iff (!nrst)
    overflow_flag ##1 !overflow_flag);
endmodule // tcr_timer
`default_nettype wire

// ===== verification/tcr_osc_model.sv
// Purpose: External count clock and crystal source for the timer
// Assumes: Both pins stand low between bursts
// Notes: Behavioural, one burst at a time
`timescale 1ns/1ps
`default_nettype none
module tcr_osc_model (
  output logic ext_pin,
  output logic osc_pin
);
  initial begin
    ext_pin = 1'b0;
    osc_pin = 1'b0;
  end

  // ----------------------------------------------------------------
  // Pulse burst
  // ----------------------------------------------------------------
  // First rise comes before any fall, so n pulses count n-1
  task automatic burst(input int n, input bit use_osc, input int half);
    #1;
    for (int i = 0; i < n; i++) begin
      if (use_osc) osc_pin = 1'b1;
      else ext_pin = 1'b1;
      #(half);
      if (use_osc) osc_pin = 1'b0;
      else ext_pin = 1'b0;
      #(half);
    end
  endtask
endmodule // tcr_osc_model
`default_nettype wire

// ===== verification/tcr_timer_tb.sv
// Purpose: Self-checking bench for the sixteen-bit timer/counter
// Assumes: Zero-wait AHB-Lite slave, 250 MHz core clock
// Notes: Count pulses come from the oscillator model or, with the internal source, the core clock
`timescale 1ns/1ps
`default_nettype none
module tcr_timer_tb;
  import tcr_pkg::*;
  logic core_clk, nrst, hsel, hwrite, hrdy, hresp, sleep;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic osc_out_en, adc_start, irq, ext_pin, osc_pin;
  logic [15:0] v;
  tcr_cmp_type cmp;
  int bad_count, checks, adc_n, a0;

  tcr_timer dut_u (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
    .hrdata(hrdata), .ext_clk_pin(ext_pin), .osc_in_pin(osc_pin),
    .osc_out_en(osc_out_en), .sleep(sleep), .cmp(cmp),
    .adc_start(adc_start), .irq(irq));
  tcr_osc_model osc_u (.ext_pin(ext_pin), .osc_pin(osc_pin));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (adc_start === 1'b1) adc_n++;

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_le(input logic [15:0] lo, input logic [15:0] hi);
    checks++;
    if ((lo <= hi) !== 1'b1) begin
      bad_count++;
      $display("MISMATCH t=%0t %h above %h", $time, lo, hi);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic wr,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00, a};
    hwrite <= wr;
    @(posedge core_clk);
    while (hrdy !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge core_clk);
    while (hrdy !== 1'b1) @(posedge core_clk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(a, 1'b0, 32'h0, q);
  endtask
  task automatic rd16(output logic [15:0] c);
    logic [31:0] h1, l, h2;
    rd(TCR_OFS_COUNT_HI, h1);
    rd(TCR_OFS_COUNT_LO, l);
    rd(TCR_OFS_COUNT_HI, h2);
    if (h1 !== h2) begin
      rd(TCR_OFS_COUNT_HI, h1);
      rd(TCR_OFS_COUNT_LO, l);
    end
    c = {h1[7:0], l[7:0]};
  endtask
  task automatic wr16(input logic [15:0] c);
    wr(TCR_OFS_COUNT_LO, 32'h0);
    wr(TCR_OFS_COUNT_HI, {24'h00, c[15:8]});
    wr(TCR_OFS_COUNT_LO, {24'h00, c[7:0]});
  endtask
  task automatic summarize;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    summarize;
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sleep = 1'b0;
    cmp = '0;
    bad_count = 0;
    checks = 0;
    adc_n = 0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    rd(TCR_OFS_CTRL, r);
    chk(r, 32'h0);
    rd(8'h20, r);
    chk(r, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    wr16(16'h1234);
    rd16(v);
    chk({16'h0, v}, 32'h1234);
    for (int p = 0; p < 4; p++) begin
      wr16(16'h0000);
      wr(TCR_OFS_CTRL, {26'h0, p[1:0], 4'h3});
      osc_u.burst(9, 1'b0, 41);
      wr(TCR_OFS_CTRL, 32'h0);
      rd16(v);
      chk({16'h0, v}, 32'h8 >> p);
    end
    wr(TCR_OFS_IRQ_EN, 32'h1);
    wr16(16'hFFFE);
    wr(TCR_OFS_CTRL, 32'h1);
    wr(TCR_OFS_CTRL, 32'h0);
    rd(TCR_OFS_STATUS, r);
    chk(r, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd16(v);
    chk_le(v, 16'h0010);
    wr(TCR_OFS_IRQ_EN, 32'h0);
    @(negedge core_clk);
    chk({31'h0, irq}, 32'h0);
    wr(TCR_OFS_STATUS, 32'h1);
    rd(TCR_OFS_STATUS, r);
    chk(r, 32'h0);
    cmp <= {TCR_MODE_SPECIAL_TRIG, 16'h0010, 1'b1};
    wr16(16'h0000);
    a0 = adc_n;
    wr(TCR_OFS_CTRL, 32'h1);
    repeat (60) @(posedge core_clk);
    wr(TCR_OFS_CTRL, 32'h0);
    rd16(v);
    chk_le(v, 16'h0010);
    chk_le(16'h3, 16'(adc_n - a0));
    wr16(16'h000E);
    wr(TCR_OFS_CTRL, 32'h7);
    osc_u.burst(7, 1'b0, 41);
    wr(TCR_OFS_CTRL, 32'h0);
    rd16(v);
    chk({16'h0, v}, 32'h14);
    cmp <= '0;
    wr16(16'hFFFE);
    wr(TCR_OFS_IRQ_EN, 32'h1);
    wr(TCR_OFS_CTRL, 32'hF);
    @(negedge core_clk);
    chk({31'h0, osc_out_en}, 32'h1);
    repeat (50) @(posedge core_clk);
    sleep <= 1'b1;
    osc_u.burst(5, 1'b1, 41);
    sleep <= 1'b0;
    @(negedge core_clk);
    chk({31'h0, irq}, 32'h1);
    wr(TCR_OFS_COUNT_HI, 32'h80);
    wr(TCR_OFS_STATUS, 32'h1);
    wr(TCR_OFS_CTRL, 32'h0);
    rd16(v);
    chk({16'h0, v}, 32'h8002);
    wr16(16'h0000);
    wr(TCR_OFS_CTRL, 32'hB);
    sleep <= 1'b1;
    osc_u.burst(5, 1'b1, 41);
    sleep <= 1'b0;
    wr(TCR_OFS_CTRL, 32'h0);
    rd16(v);
    chk({16'h0, v}, 32'h0);
    wr16(16'hA55A);
    wr(TCR_OFS_CTRL, 32'h30);
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    rd(TCR_OFS_CTRL, r);
    chk(r, 32'h0);
    rd16(v);
    chk({16'h0, v}, 32'hA55A);
    summarize;
  end
endmodule // tcr_timer_tb
`default_nettype wire
